// *** hw/adc_sequencer_control.sv ***
// Digital sequencer for a successive-approximation converter and comparator.
// Holds the four control and result registers behind a Wishbone slave.
// Assumes the analog core answers with a 12-bit code and a compare bit.
// Assumes that code and bit are steady before the end cycle; both pass two stages.
// Assumes one clock and a synchronous, active-low reset.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control (
	input  wire logic                  core_clk_i,      // 25 MHz system clock
	input  wire logic                  rst_n_i,         // Synchronous reset, active low
	input  wire adc_seq_pkg::wb_req_s  wb_req_i,        // Wishbone request bundle
	output logic [7:0]                 wb_dat_o,        // Wishbone read data
	output logic                       wb_ack_o,        // Wishbone acknowledge
	input  wire logic [11:0]           conv_code_i,     // Analog core result code
	input  wire logic                  cmp_above_i,     // Analog core compare outcome
	output logic [10:0]                input_route_o,   // One-hot analog input route
	output logic                       ref_enable_o,    // Reference generator enable
	output logic                       compare_run_o,   // Comparator operation active
	output logic                       irq_o            // Interrupt request level
);

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------

	logic [7:0]              adc_control;
	logic [7:0]              adc_mode;
	logic [7:0]              adc_result_low;
	logic [7:0]              adc_result_high;
	adc_seq_pkg::seq_state_e state;
	logic [8:0]              cnt;
	logic                    need_double;
	logic                    last_res8;
	logic                    wb_ack;

	// Analog core sampling stages
	logic [11:0]             code_meta;
	logic [11:0]             code_sync;
	logic                    cmp_meta;
	logic                    cmp_sync;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------

	// Taken request and per-register address hits
	wire       bus_req  = wb_req_i.cyc & wb_req_i.stb & ~wb_ack;
	wire       hit_control = (wb_req_i.adr == adc_seq_pkg::ADDR_CONTROL);
	wire       hit_mode = (wb_req_i.adr == adc_seq_pkg::ADDR_MODE);
	wire       hit_low  = (wb_req_i.adr == adc_seq_pkg::ADDR_RESULT_LOW);
	wire       hit_high = (wb_req_i.adr == adc_seq_pkg::ADDR_RESULT_HIGH);

	// Write strobes, taken on the request edge
	wire       bus_wr  = bus_req & wb_req_i.we & wb_req_i.sel;
	wire       wr_ctl  = bus_wr & hit_control;
	wire       wr_mode = bus_wr & hit_mode;
	wire       wr_low  = bus_wr & hit_low;
	wire       wr_high = bus_wr & hit_high;
	wire [7:0] wdat    = wb_req_i.dat;

	// ----------------------------------------
	// Field views
	// ----------------------------------------

	// Control fields
	wire [3:0] input_select        = adc_control[adc_seq_pkg::CTL_SEL_MSB:adc_seq_pkg::CTL_SEL_LSB];
	wire       compare_mode_select = adc_control[adc_seq_pkg::CTL_CMP_BIT];
	wire       start_bit           = adc_control[adc_seq_pkg::CTL_START_BIT];
	wire       done_flag           = adc_control[adc_seq_pkg::CTL_DONE_BIT];
	wire       irq_enable          = adc_control[adc_seq_pkg::CTL_IE_BIT];

	// Mode fields
	wire       bit_width_select    = adc_mode[adc_seq_pkg::MODE_RES_BIT];
	wire [1:0] time_div_low_bits   = adc_mode[adc_seq_pkg::MODE_DIV_MSB:adc_seq_pkg::MODE_DIV_LSB];

	// Divider code spans two registers
	wire       time_div_high_bit   = adc_result_low[adc_seq_pkg::LOW_DIV_BIT];
	wire [2:0] div_code            = {time_div_high_bit, time_div_low_bits};

	// ----------------------------------------
	// Duration: steps shifted by ratio, plus fixed cycles
	// ----------------------------------------

	// Step count for the chosen resolution
	wire [7:0] steps     = bit_width_select ? adc_seq_pkg::STEPS_8 : adc_seq_pkg::STEPS_12;

	// Divide by the ratio, then add fixed cycles
	wire [7:0] scaled    = steps >> div_code;
	wire [7:0] base_cyc  = scaled + adc_seq_pkg::EXTRA_CYC;

	// Doubled for the first 12-bit conversion
	wire       dbl       = need_double & ~bit_width_select & ~compare_mode_select;
	wire [8:0] run_cyc   = dbl ? {base_cyc, 1'b0} : {1'b0, base_cyc};

	// ----------------------------------------
	// Sequencing events
	// ----------------------------------------

	// Busy view of the state
	wire busy      = (state == adc_seq_pkg::ST_BUSY);

	// Start only from idle
	wire start_req = wr_ctl & wdat[adc_seq_pkg::CTL_START_BIT] & (state == adc_seq_pkg::ST_IDLE);
	// Abort: start written to zero while busy
	wire abort_req = wr_ctl & ~wdat[adc_seq_pkg::CTL_START_BIT] & busy;
	// Normal end on the last counted cycle
	wire finish    = busy & (cnt == 9'd1) & ~abort_req;

	// ----------------------------------------
	// Control register next value
	// ----------------------------------------

	// Done set beats a software clear
	wire next_done  = finish | (wr_ctl ? wdat[adc_seq_pkg::CTL_DONE_BIT] : done_flag);
	// Start self-clears in the done cycle
	wire next_start = finish ? 1'b0 : (wr_ctl ? wdat[adc_seq_pkg::CTL_START_BIT] : start_bit);

	// Remaining fields follow software
	wire [7:0] ctl_src    = wr_ctl ? wdat : adc_control;
	wire [7:0] next_control = {ctl_src[7:3], next_start, next_done, ctl_src[0]};

	// ----------------------------------------
	// Result placement at finish
	// ----------------------------------------

	// Operation outcome strobes
	wire       res_cmp    = finish & compare_mode_select;
	wire       res_conv   = finish & ~compare_mode_select;

	// Software write through the writable mask
	wire [7:0] low_wr     = (adc_result_low & ~adc_seq_pkg::LOW_WMASK) | (wdat & adc_seq_pkg::LOW_WMASK);
	wire [7:0] low_base   = wr_low ? low_wr : adc_result_low;

	// Compare bit and 12-bit nibble placement
	wire [7:0] low_cmp    = {cmp_sync, low_base[6:0]};
	wire [7:0] low_conv12 = {code_sync[3:0], low_base[3:0]};

	// Result low: compare, 12-bit nibble, else held
	wire [7:0] low_after_conv  = (res_conv & ~bit_width_select) ? low_conv12 : low_base;
	wire [7:0] next_result_low = res_cmp ? low_cmp : low_after_conv;

	// Result high: upper code, else software value
	wire [7:0] next_result_high = res_conv ? code_sync[11:4] :
	                              (wr_high ? wdat : adc_result_high);

	// Mode register write through its mask
	wire [7:0] next_mode  = wr_mode ? (wdat & adc_seq_pkg::MODE_WMASK) : adc_mode;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------

	// Unmapped places read zero
	wire [7:0] rd_data = ({8{hit_control}} & adc_control) |
	                     ({8{hit_mode}}    & adc_mode) |
	                     ({8{hit_low}}     & adc_result_low) |
	                     ({8{hit_high}}    & adc_result_high);

	// ----------------------------------------
	// Input routing
	// ----------------------------------------

	// One line per analog input, none for spare codes
	genvar g;
	generate
		for (g = 0; g < 11; g++) begin : g_route
			assign input_route_o[g] = (input_select == 4'(g)) & (input_select <= adc_seq_pkg::SEL_LAST);
		end
	endgenerate

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------

	// Reference and comparator follow the state
	assign ref_enable_o  = busy;
	assign compare_run_o = busy & compare_mode_select;

	// Interrupt level and bus ack
	assign irq_o         = irq_enable & done_flag;
	assign wb_ack_o      = wb_ack;

	// ----------------------------------------
	// Bus slave: one registered ack per request, one cycle after it
	// ----------------------------------------

	// Ack pulse, dropped the cycle after it is given
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wb_ack <= 1'b0;
		end else begin
			wb_ack <= bus_req;
		end
	end

	// Read data captured together with the ack
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wb_dat_o <= 8'h00;
		end else begin
			wb_dat_o <= rd_data;
		end
	end

	// ----------------------------------------
	// Analog core sampling
	// ----------------------------------------

	// First stage of the result code
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			code_meta <= 12'h000;
		end else begin
			code_meta <= conv_code_i;
		end
	end

	// Second stage, sole reader of the first
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			code_sync <= 12'h000;
		end else begin
			code_sync <= code_meta;
		end
	end

	// First stage of the compare outcome
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cmp_meta <= 1'b0;
		end else begin
			cmp_meta <= cmp_above_i;
		end
	end

	// Second stage of the compare outcome
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cmp_sync <= 1'b0;
		end else begin
			cmp_sync <= cmp_meta;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------

	// Control register: fields, start and done
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			adc_control <= adc_seq_pkg::RESET_VALUE;
		end else begin
			adc_control <= next_control;
		end
	end

	// Mode register, fixed bits kept at zero
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			adc_mode <= adc_seq_pkg::RESET_VALUE;
		end else begin
			adc_mode <= next_mode;
		end
	end

	// Result low: nibble, compare bit, divider bit
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			adc_result_low <= adc_seq_pkg::RESET_VALUE;
		end else begin
			adc_result_low <= next_result_low;
		end
	end

	// Result high: upper code or software value
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			adc_result_high <= adc_seq_pkg::RESET_VALUE;
		end else begin
			adc_result_high <= next_result_high;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------

	// Idle and busy state
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= adc_seq_pkg::ST_IDLE;
		end else begin
			unique case (state)
				adc_seq_pkg::ST_IDLE: begin
					if (start_req) begin
						state <= adc_seq_pkg::ST_BUSY;
					end
				end
				adc_seq_pkg::ST_BUSY: begin
					if (abort_req || finish) begin
						state <= adc_seq_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Duration counter: loaded at start, counts down while busy
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cnt <= 9'd0;
		end else if (start_req) begin
			cnt <= run_cyc;
		end else if (busy) begin
			cnt <= cnt - 9'd1;
		end
	end

	// ----------------------------------------
	// Double-duration tracking after reset or 8-to-12 switch
	// ----------------------------------------

	// Previous resolution, to see the 8-to-12 switch
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			last_res8 <= 1'b0;
		end else begin
			last_res8 <= bit_width_select;
		end
	end

	// Armed by reset or switch, spent by a doubled run
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			need_double <= 1'b1;
		end else if (last_res8 && !bit_width_select) begin
			need_double <= 1'b1;
		end else if (finish && dbl) begin
			need_double <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** hw/adc_seq_pkg.sv ***
// Constants, field positions, timing and carrier types for the converter sequencer.
// Assumes an 8-bit register file behind a classic Wishbone slave on one clock.
package adc_seq_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [15:0] ADDR_CONTROL     = 16'h7F20;
	localparam logic [15:0] ADDR_MODE        = 16'h7F21;
	localparam logic [15:0] ADDR_RESULT_LOW  = 16'h7F22;
	localparam logic [15:0] ADDR_RESULT_HIGH = 16'h7F23;
	localparam logic [7:0]  RESET_VALUE      = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_SEL_MSB   = 7;
	localparam int CTL_SEL_LSB   = 4;
	localparam int CTL_CMP_BIT   = 3;
	localparam int CTL_START_BIT = 2;
	localparam int CTL_DONE_BIT  = 1;
	localparam int CTL_IE_BIT    = 0;
	localparam int MODE_RES_BIT  = 6;
	localparam int MODE_ADJ_BIT  = 2;
	localparam int MODE_DIV_MSB  = 1;
	localparam int MODE_DIV_LSB  = 0;
	localparam int LOW_CMP_BIT   = 7;
	localparam int LOW_DIV_BIT   = 0;
	localparam logic [7:0] MODE_WMASK = 8'h47;
	localparam logic [7:0] LOW_WMASK  = 8'hF1;

	// ----------------------------------------
	// Selection and timing
	// ----------------------------------------
	localparam logic [3:0] SEL_LAST   = 4'hA;
	localparam logic [7:0] STEPS_12   = 8'd52;
	localparam logic [7:0] STEPS_8    = 8'd32;
	localparam logic [7:0] EXTRA_CYC  = 8'd2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} seq_state_e;

	typedef struct packed {
		logic [15:0] adr;
		logic [7:0]  dat;
		logic        we;
		logic        sel;
		logic        cyc;
		logic        stb;
	} wb_req_s;

endpackage

// *** verification/adc_seq_sva.sv ***
// Port checker for the converter sequencer.
// Assumes it is bound into adc_sequencer_control on one clock.
`timescale 1ns/100ps
`default_nettype none
module adc_seq_sva (
	input wire logic                 core_clk_i,
	input wire logic                 rst_n_i,
	input wire adc_seq_pkg::wb_req_s wb_req_i,
	input wire logic                 wb_ack_o,
	input wire logic [10:0]          input_route_o,
	input wire logic                 ref_enable_o,
	input wire logic                 compare_run_o,
	input wire logic                 irq_o
);
	// Taken request and control write decode
	wire req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
	wire cw = req & wb_req_i.we & wb_req_i.sel & (wb_req_i.adr == adc_seq_pkg::ADDR_CONTROL);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Port relations
	property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse");
	property p_route; $onehot0(input_route_o); endproperty
	a_route: assert property (p_route) else $error("route not one-hot");
	property p_cmp; compare_run_o |-> ref_enable_o; endproperty
	a_cmp: assert property (p_cmp) else $error("compare without run");
	property p_start; $rose(ref_enable_o) |-> $past(cw & wb_req_i.dat[2]); endproperty
	a_start: assert property (p_start) else $error("run without start");
	property p_abort; cw & !wb_req_i.dat[2] & ref_enable_o |=> !ref_enable_o; endproperty
	a_abort: assert property (p_abort) else $error("abort ignored");
	property p_irq_fall; $fell(irq_o) |-> $past(req & wb_req_i.we); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
	property p_irq_rise; $rose(irq_o) |-> $past(req & wb_req_i.we) || $fell(ref_enable_o); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
	property p_min; $rose(ref_enable_o) |-> ref_enable_o[*2]; endproperty
	a_min: assert property (p_min) else $error("run too short");
	// Main scenarios
	c_cmp: cover property ($rose(compare_run_o));
	c_irq: cover property ($rose(irq_o));
	c_abort: cover property (cw && !wb_req_i.dat[2] && ref_enable_o);
endmodule
bind adc_sequencer_control adc_seq_sva chk (.core_clk_i, .rst_n_i, .wb_req_i, .wb_ack_o,
	.input_route_o, .ref_enable_o, .compare_run_o, .irq_o);
`default_nettype wire

// *** verification/adc_sequencer_control_bench.sv ***
// Self-checking bench for the converter sequencer.
// Assumes the analog core is stood in for by fixed codes.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control_bench;
	logic core_clk_i, rst_n_i, wb_ack_o, cmp_above_i, ref_enable_o, compare_run_o, irq_o;
	adc_seq_pkg::wb_req_s wb_req_i;
	logic [7:0]  wb_dat_o, q;
	logic [11:0] conv_code_i;
	logic [10:0] input_route_o;
	int          err_total, n_tests;
	adc_sequencer_control dut (.core_clk_i, .rst_n_i, .wb_req_i, .wb_dat_o, .wb_ack_o,
		.conv_code_i, .cmp_above_i, .input_route_o, .ref_enable_o, .compare_run_o, .irq_o);
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Compare seen with expected
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// One classic Wishbone cycle
	task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
		int n = 0;
		@(posedge core_clk_i);
		wb_req_i <= '{adr: a, dat: d, we: w, sel: 1'b1, cyc: 1'b1, stb: 1'b1};
		do begin
			@(posedge core_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_req_i <= '0;
		if (n >= 50) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(16'(q), 16'(e));
	endtask
	// Start, then count cycles with the reference on
	task automatic conv(input logic [7:0] c, input int e);
		int n = 0;
		bus(16'h7F20, 1'b1, c);
		chk(16'(compare_run_o), 16'(c[3]));
		while (ref_enable_o === 1'b1 && n < 300) begin
			n++;
			@(posedge core_clk_i);
		end
		chk(16'(n), 16'(e));
		if (n >= 300) begin
			err_total++;
			close_out();
		end
	endtask
	// Reset values, masks, unmapped place, routing
	task automatic t_regs;
		rd(16'h7F23, 8'h00);
		bus(16'h7F24, 1'b1, 8'hFF);
		rd(16'h7F24, 8'h00);
		rd(16'h7F20, 8'h00);
		bus(16'h7F21, 1'b1, 8'hFF);
		rd(16'h7F21, 8'h47);
		bus(16'h7F22, 1'b1, 8'hFF);
		rd(16'h7F22, 8'hF1);
		for (int c = 0; c < 16; c++) begin
			bus(16'h7F20, 1'b1, 8'(c << 4));
			chk(16'(input_route_o), c < 11 ? 16'(1 << c) : 16'h0000);
		end
		$display("regs end");
	endtask
	// All divider codes in 8-bit mode, then 12-bit
	task automatic t_conv;
		for (int k = 0; k < 8; k++) begin
			bus(16'h7F22, 1'b1, {7'h28, k[2]});
			bus(16'h7F21, 1'b1, {6'h10, k[1:0]});
			conv(8'h04, (32 >> k) + 2);
			rd(16'h7F22, {7'h28, k[2]});
			rd(16'h7F23, 8'h5A);
		end
		conv_code_i <= 12'hABC;
		bus(16'h7F21, 1'b1, 8'h00);
		bus(16'h7F22, 1'b1, 8'h01);
		conv(8'h04, 10);
		rd(16'h7F20, 8'h02);
		rd(16'h7F23, 8'hAB);
		rd(16'h7F22, 8'hC1);
		conv(8'h04, 5);
		$display("conv end");
	endtask
	// Comparator, abort, interrupt
	task automatic t_misc;
		cmp_above_i <= 1'b1;
		bus(16'h7F21, 1'b1, 8'h04);
		bus(16'h7F23, 1'b1, 8'h80);
		bus(16'h7F22, 1'b1, 8'h01);
		conv(8'h0C, 5);
		rd(16'h7F22, 8'h81);
		bus(16'h7F22, 1'b1, 8'h00);
		bus(16'h7F20, 1'b1, 8'h04);
		bus(16'h7F20, 1'b1, 8'h00);
		chk(16'(ref_enable_o), 16'h0000);
		rd(16'h7F20, 8'h00);
		rd(16'h7F23, 8'h80);
		conv(8'h05, 54);
		chk(16'(irq_o), 16'h0001);
		rd(16'h7F20, 8'h03);
		bus(16'h7F20, 1'b1, 8'h01);
		chk(16'(irq_o), 16'h0000);
		$display("misc end");
	endtask
	initial begin
		err_total = 0;
		n_tests = 0;
		rst_n_i = 1'b0;
		wb_req_i = '0;
		conv_code_i = 12'h5A3;
		cmp_above_i = 1'b0;
		repeat (6) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_conv();
		t_misc();
		close_out();
	end
endmodule
`default_nettype wire
